// file: include/bvic_pkg.sv
// Package for the blind/value input channel: register map, field layout,
// reset values, enumerations and timing figures.
// Assumes a 10 MHz APB clock and a contact input already synchronous to it.
`default_nettype none
package bvic_pkg;
    // Time base: all press timers count ticks of this period.
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned TICK_MS = 10;
    localparam int unsigned TICK_NS = TICK_MS * 1_000_000;
    localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    // Selectable time bases in milliseconds.
    localparam int unsigned BASE0_MS = 130;
    localparam int unsigned BASE1_MS = 260;
    localparam int unsigned BASE2_MS = 520;
    localparam int unsigned BASE3_MS = 1000;
    localparam int unsigned BASE4_MS = 2100;
    localparam int unsigned BASE5_MS = 4200;
    localparam int unsigned BASE6_MS = 8400;
    localparam int unsigned BASE7_MS = 17000;
    localparam int unsigned BASE8_MS = 34000;
    localparam logic [6:0] T1_FACTOR_MIN = 7'h04;
    localparam logic [6:0] T2_FACTOR_MIN = 7'h03;
    localparam logic [6:0] CYC_FACTOR_MIN = 7'h03;
    localparam logic [3:0] STEP_MIN = 4'h1;
    localparam logic [3:0] STEP_MAX = 4'ha;
    // Register byte offsets.
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_BLIND = 8'h04;
    localparam logic [7:0] OFF_VALCFG = 8'h08;
    localparam logic [7:0] OFF_VALUES = 8'h0c;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_TEL = 8'h14;
    // Field positions.
    localparam int unsigned C_FUNC_BIT = 0;
    localparam int unsigned C_RETURN_BIT = 1;
    localparam int unsigned B_RISE_LSB = 0;
    localparam int unsigned B_CONCEPT_BIT = 2;
    localparam int unsigned B_T1B_LSB = 3;
    localparam int unsigned B_T1F_LSB = 7;
    localparam int unsigned B_T2B_LSB = 14;
    localparam int unsigned B_T2F_LSB = 18;
    localparam int unsigned B_RET_LSB = 25;
    localparam int unsigned V_FUNC_LSB = 0;
    localparam int unsigned V_EDGE_LSB = 3;
    localparam int unsigned V_ADJ_BIT = 5;
    localparam int unsigned V_CYB_LSB = 6;
    localparam int unsigned V_CYF_LSB = 8;
    localparam int unsigned V_STEP_LSB = 15;
    localparam int unsigned V_RET_LSB = 19;
    localparam int unsigned D_RISE_LSB = 0;
    localparam int unsigned D_FALL_LSB = 8;
    localparam int unsigned D_SRISE_LSB = 16;
    localparam int unsigned D_SFALL_LSB = 24;
    // Reset values.
    localparam logic [31:0] RST_CTRL = 32'h0000_0000;
    localparam logic [31:0] RST_BLIND = 32'h0050_0201;
    localparam logic [31:0] RST_VALCFG = 32'h0000_8380;
    localparam logic [31:0] RST_VALUES = 32'h0101_0064;

    typedef enum {ST_IDLE, ST_THRESH, ST_SLAT, ST_HOLD} bvic_state_t;
    typedef enum logic [1:0] {TK_STEP, TK_MOVE, TK_VALUE, TK_SCENE} bvic_kind_t;
    typedef enum logic [1:0] {RC_NONE, RC_UP, RC_DOWN, RC_TOGGLE} bvic_rise_t;
    typedef enum logic [1:0] {EM_RISE, EM_FALL, EM_BOTH, EM_RSVD} bvic_edge_t;
    typedef enum logic [2:0] {VF_DIM, VF_SCENE, VF_SCENE_MEM, VF_TEMP, VF_BRIGHT,
        VF_R5, VF_R6, VF_R7} bvic_vfunc_t;
    typedef enum logic [1:0] {BR_NONE, BR_UP, BR_DOWN, BR_RSVD} bvic_bret_t;
    typedef enum logic [1:0] {VR_NONE, VR_RISE, VR_FALL, VR_STATE} bvic_vret_t;

    // One bus telegram: dir is 0 for up, 1 for down.
    typedef struct packed {
        bvic_kind_t kind;
        logic dir;
        logic [7:0] data;
    } bvic_tel_t;

    function automatic logic [11:0] base_ticks(input logic [3:0] idx);
        case (idx)
            4'h0: base_ticks = 12'(BASE0_MS / TICK_MS);
            4'h1: base_ticks = 12'(BASE1_MS / TICK_MS);
            4'h2: base_ticks = 12'(BASE2_MS / TICK_MS);
            4'h3: base_ticks = 12'(BASE3_MS / TICK_MS);
            4'h4: base_ticks = 12'(BASE4_MS / TICK_MS);
            4'h5: base_ticks = 12'(BASE5_MS / TICK_MS);
            4'h6: base_ticks = 12'(BASE6_MS / TICK_MS);
            4'h7: base_ticks = 12'(BASE7_MS / TICK_MS);
            default: base_ticks = 12'(BASE8_MS / TICK_MS);
        endcase
    endfunction

    // Factors below the documented minimum are raised to it.
    function automatic logic [18:0] time_limit(input logic [3:0] idx, input logic [6:0] f,
        input logic [6:0] fmin);
        logic [6:0] fe;
        fe = (f < fmin) ? fmin : f;
        // Both operands are widened first so the longest times cannot overflow.
        time_limit = {7'h00, base_ticks(idx)} * {12'h000, fe};
    endfunction
endpackage
`default_nettype wire

// file: hdl/bvic_channel.sv
// Blind / value input channel: turns contact edges into bus telegrams.
// Assumes contact_in is debounced and synchronous to pclk, and that the
// bus-return delay is timed outside; software sets CTRL.return when it ends.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RL1: Rising-edge command: none, up, down, toggle.
// RL2: Up: short press step, long move up.
// RL3: Down: short press step, long move down.
// RL4: Toggle inverts held direction each long press.
// RL5: Toggle step opposes last move direction.
// RL6: Short-long-short: step, start threshold, release silent.
// RL7: Threshold expiry moves; release in window steps.
// RL8: Long-short: move first, release in window steps.
// RL9: Threshold is base times factor, min four.
// RL10: Slat window is base times factor, min three.
// RL11: Blind return reaction: nothing, move up, down.
// RL12: Value function selects dimming, scene, or others; the code sends telegrams only for dimming and scene.
// RL13: Value actuation on rising, falling or both.
// RL14: Rising-edge dimming value, default one hundred.
// RL15: Falling-edge dimming value, zero to 255.
// RL16: Long press adjusts value cyclically by step.
// RL17: Cyclic interval is base times factor.
// RL18: Adjustment step width one to ten.
// RL19: Value return reaction with compatible edge modes.
// RL20: Current state sends rise or fall value.
// RL21: Rising-edge scene number one to sixty-four.
// RL22: Falling-edge scene number one to sixty-four.
// RL23: Adjustment saturates; timers count common tick.
module bvic_channel #(
    parameter int unsigned TICK_CYC = bvic_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic contact_in,
    output bvic_pkg::bvic_tel_t tel,
    output logic tel_valid
);
    import bvic_pkg::*;

    logic [31:0] ctrl_reg, blind_reg, valcfg_reg, values_reg;
    logic [31:0] prdata_reg;
    logic pready_reg, pslverr_reg;
    bvic_tel_t tel_reg, tel_next;
    logic tel_valid_reg, tel_valid_next;
    bvic_state_t state_reg, state_next;
    logic in_prev_reg;
    logic [31:0] pre_reg;
    logic [18:0] tcnt_reg;
    logic move_dir_reg, move_dir_next;
    logic [7:0] cur_val_reg, cur_val_next;
    logic adj_up_reg, adj_up_next;
    logic adjusted_reg, adjusted_next;
    logic ret_pend_reg, ret_pend_next;
    logic restart;

    // Bus decode.
    wire setup = psel & ~penable;
    wire access = psel & penable & pready_reg;
    wire wr_en = access & pwrite;
    wire hit_ctrl = paddr == OFF_CTRL;
    wire hit_blind = paddr == OFF_BLIND;
    wire hit_valcfg = paddr == OFF_VALCFG;
    wire hit_values = paddr == OFF_VALUES;
    wire hit_status = paddr == OFF_STATUS;
    wire hit_tel = paddr == OFF_TEL;
    wire mapped = hit_ctrl | hit_blind | hit_valcfg | hit_values | hit_status | hit_tel;
    wire ret_req = wr_en & hit_ctrl & pwdata[C_RETURN_BIT];
    wire cfg_wr = wr_en & (hit_valcfg | hit_values);

    // Configuration fields.
    wire func_value = ctrl_reg[C_FUNC_BIT];
    wire bvic_rise_t rise_cmd = bvic_rise_t'(blind_reg[B_RISE_LSB +: 2]);
    wire concept_ls = blind_reg[B_CONCEPT_BIT];
    wire bvic_bret_t blind_ret = bvic_bret_t'(blind_reg[B_RET_LSB +: 2]);
    wire bvic_vfunc_t vfunc = bvic_vfunc_t'(valcfg_reg[V_FUNC_LSB +: 3]);
    wire bvic_edge_t edge_mode = bvic_edge_t'(valcfg_reg[V_EDGE_LSB +: 2]);
    wire adj_en = valcfg_reg[V_ADJ_BIT];
    wire bvic_vret_t val_ret = bvic_vret_t'(valcfg_reg[V_RET_LSB +: 2]);
    wire [7:0] rise_val = values_reg[D_RISE_LSB +: 8];
    wire [7:0] fall_val = values_reg[D_FALL_LSB +: 8];
    wire [7:0] scene_rise = {1'b0, values_reg[D_SRISE_LSB +: 7]};
    wire [7:0] scene_fall = {1'b0, values_reg[D_SFALL_LSB +: 7]};
    wire [3:0] step_raw = valcfg_reg[V_STEP_LSB +: 4];
    // RL18 step clamp
    wire [3:0] step_w = (step_raw < STEP_MIN) ? STEP_MIN :
        (step_raw > STEP_MAX) ? STEP_MAX : step_raw;
    // A new edge mode or new edge values restart adjustment from the configured value.
    wire [31:0] load_vals = hit_values ? pwdata : values_reg;
    wire [1:0] load_edge = hit_valcfg ? pwdata[V_EDGE_LSB +: 2] : edge_mode;
    wire [7:0] load_val = (load_edge == EM_FALL) ? load_vals[D_FALL_LSB +: 8] :
        load_vals[D_RISE_LSB +: 8];

    // Contact edges.
    wire rise = contact_in & ~in_prev_reg;
    wire fall = ~contact_in & in_prev_reg;

    // RL9 threshold time
    wire [18:0] t1_lim = time_limit(blind_reg[B_T1B_LSB +: 4], blind_reg[B_T1F_LSB +: 7],
        T1_FACTOR_MIN);
    // RL10 slat window
    wire [18:0] t2_lim = time_limit(blind_reg[B_T2B_LSB +: 4], blind_reg[B_T2F_LSB +: 7],
        T2_FACTOR_MIN);
    // RL17 cyclic interval
    wire [18:0] cyc_lim = time_limit({2'b00, valcfg_reg[V_CYB_LSB +: 2]},
        valcfg_reg[V_CYF_LSB +: 7], CYC_FACTOR_MIN);
    wire [18:0] limit = (state_reg == ST_THRESH) ? t1_lim :
        (state_reg == ST_SLAT) ? t2_lim : cyc_lim;
    wire tick = pre_reg == TICK_CYC - 1;
    // RL23 common tick
    wire t_done = tcnt_reg >= limit;

    // RL4 toggle direction
    // RL5 step opposes move
    wire step_dir = (rise_cmd == RC_TOGGLE) ? ~move_dir_reg : (rise_cmd == RC_DOWN);

    // RL12 supported functions
    wire val_ok = (vfunc == VF_DIM) | (vfunc == VF_SCENE);
    wire single = (edge_mode == EM_RISE) | (edge_mode == EM_FALL);
    wire adj_ok = adj_en & single & (vfunc == VF_DIM);
    // RL13 edge selection
    wire act_rise = rise & ((edge_mode == EM_RISE) | (edge_mode == EM_BOTH));
    wire act_fall = fall & ((edge_mode == EM_FALL) | (edge_mode == EM_BOTH));
    // RL14 rising value
    // RL21 rising scene
    wire [7:0] rise_data = (vfunc == VF_SCENE) ? scene_rise : (adj_ok ? cur_val_reg : rise_val);
    // RL15 falling value
    // RL22 falling scene
    wire [7:0] fall_data = (vfunc == VF_SCENE) ? scene_fall : (adj_ok ? cur_val_reg : fall_val);
    wire bvic_kind_t val_kind = bvic_kind_t'((vfunc == VF_SCENE) ? TK_SCENE : TK_VALUE);
    wire release_hold = (edge_mode == EM_FALL) ? rise : fall;

    // RL23 saturating step
    function automatic logic [7:0] adj_sat(input logic [7:0] v, input logic [3:0] s,
        input logic up);
        logic [8:0] t;
        t = 9'h000;
        if (up) begin
            t = {1'b0, v} + {5'h00, s};
            adj_sat = t[8] ? 8'hff : t[7:0];
        end else begin
            adj_sat = (v < {4'h0, s}) ? 8'h00 : v - {4'h0, s};
        end
    endfunction

    always_comb begin
        state_next = state_reg;
        tel_next = tel_reg;
        tel_valid_next = 1'b0;
        restart = 1'b0;
        move_dir_next = move_dir_reg;
        cur_val_next = cfg_wr ? load_val : cur_val_reg;
        adj_up_next = adj_up_reg;
        adjusted_next = adjusted_reg;
        ret_pend_next = ret_pend_reg | ret_req;
        case (state_reg)
            ST_IDLE: begin
                if (!func_value) begin
                    if (ret_pend_reg) begin
                        // RL11 blind return
                        ret_pend_next = ret_req;
                        if (blind_ret == BR_UP || blind_ret == BR_DOWN) begin
                            tel_valid_next = 1'b1;
                            tel_next = '{kind: TK_MOVE, dir: blind_ret == BR_DOWN, data: 8'h00};
                            move_dir_next = blind_ret == BR_DOWN;
                        end
                    end else if (rise && rise_cmd != RC_NONE) begin
                        // RL1 rising command
                        tel_valid_next = 1'b1;
                        restart = 1'b1;
                        if (concept_ls) begin
                            // RL8 move first
                            tel_next = '{kind: TK_MOVE, dir: step_dir, data: 8'h00};
                            move_dir_next = step_dir;
                            state_next = ST_SLAT;
                        end else begin
                            // RL6 step first
                            // RL2 short up
                            // RL3 short down
                            tel_next = '{kind: TK_STEP, dir: step_dir, data: 8'h00};
                            state_next = ST_THRESH;
                        end
                    end
                end else if (ret_pend_reg) begin
                    // RL19 value return
                    ret_pend_next = ret_req;
                    tel_next = '{kind: val_kind, dir: 1'b0, data: rise_data};
                    if (val_ret == VR_RISE && edge_mode != EM_FALL) begin
                        tel_valid_next = val_ok;
                    end else if (val_ret == VR_FALL && edge_mode != EM_RISE) begin
                        tel_valid_next = val_ok;
                        tel_next.data = fall_data;
                    end else if (val_ret == VR_STATE && edge_mode == EM_BOTH) begin
                        // RL20 current state
                        tel_valid_next = val_ok;
                        tel_next.data = contact_in ? rise_data : fall_data;
                    end
                end else if (val_ok && (act_rise || act_fall)) begin
                    tel_valid_next = 1'b1;
                    tel_next = '{kind: val_kind, dir: 1'b0, data: act_rise ? rise_data : fall_data};
                    if (adj_ok) begin
                        state_next = ST_HOLD;
                        restart = 1'b1;
                        adjusted_next = 1'b0;
                    end
                end
            end
            ST_THRESH: begin
                if (fall) begin
                    // RL6 release silent
                    state_next = ST_IDLE;
                end else if (t_done) begin
                    // RL7 long press move
                    tel_valid_next = 1'b1;
                    tel_next = '{kind: TK_MOVE, dir: step_dir, data: 8'h00};
                    move_dir_next = step_dir;
                    state_next = ST_SLAT;
                    restart = 1'b1;
                end
            end
            ST_SLAT: begin
                if (fall) begin
                    // RL7 window step
                    tel_valid_next = 1'b1;
                    tel_next = '{kind: TK_STEP, dir: step_dir, data: 8'h00};
                    state_next = ST_IDLE;
                end else if (t_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (release_hold) begin
                    // After a hold that adjusted, the next long press adjusts the other way.
                    state_next = ST_IDLE;
                    adj_up_next = adjusted_reg ? ~adj_up_reg : adj_up_reg;
                end else if (t_done) begin
                    // RL16 cyclic adjust
                    cur_val_next = adj_sat(cur_val_reg, step_w, adj_up_reg);
                    tel_valid_next = 1'b1;
                    tel_next = '{kind: TK_VALUE, dir: ~adj_up_reg, data: cur_val_next};
                    adjusted_next = 1'b1;
                    restart = 1'b1;
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            tel_reg <= '{kind: TK_STEP, dir: 1'b0, data: 8'h00};
            tel_valid_reg <= 1'b0;
            in_prev_reg <= 1'b0;
            move_dir_reg <= 1'b0;
            cur_val_reg <= RST_VALUES[D_RISE_LSB +: 8];
            adj_up_reg <= 1'b1;
            adjusted_reg <= 1'b0;
            ret_pend_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tel_reg <= tel_next;
            tel_valid_reg <= tel_valid_next;
            in_prev_reg <= contact_in;
            move_dir_reg <= move_dir_next;
            cur_val_reg <= cur_val_next;
            adj_up_reg <= adj_up_next;
            adjusted_reg <= adjusted_next;
            ret_pend_reg <= ret_pend_next;
        end
    end

    // Restarting the prescaler with the count keeps every timer exact to the cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_reg <= 32'h0000_0000;
            tcnt_reg <= 19'h00000;
        end else if (restart) begin
            pre_reg <= 32'h0000_0000;
            tcnt_reg <= 19'h00000;
        end else begin
            pre_reg <= tick ? 32'h0000_0000 : pre_reg + 32'h0000_0001;
            tcnt_reg <= (tick && !t_done) ? tcnt_reg + 19'h00001 : tcnt_reg;
        end
    end

    // APB slave: one wait-free access phase; read data is captured in setup.
    wire [31:0] status_word = {20'h00000, adj_up_reg, move_dir_reg, contact_in, 1'b0,
        cur_val_reg};
    wire [31:0] rd_mux = hit_ctrl ? ctrl_reg : hit_blind ? blind_reg :
        hit_valcfg ? valcfg_reg : hit_values ? values_reg :
        hit_status ? status_word : hit_tel ? {21'h000000, tel_reg} : 32'h0000_0000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= RST_CTRL;
            blind_reg <= RST_BLIND;
            valcfg_reg <= RST_VALCFG;
            values_reg <= RST_VALUES;
            prdata_reg <= 32'h0000_0000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= setup;
            pslverr_reg <= setup & ~mapped;
            prdata_reg <= (setup & ~pwrite) ? rd_mux : prdata_reg;
            if (wr_en && hit_ctrl) ctrl_reg <= {31'h0000_0000, pwdata[C_FUNC_BIT]};
            if (wr_en && hit_blind) blind_reg <= pwdata;
            if (wr_en && hit_valcfg) valcfg_reg <= pwdata;
            if (wr_en && hit_values) values_reg <= pwdata;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign tel = tel_reg;
    assign tel_valid = tel_valid_reg;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire idle_press = state_reg == ST_IDLE && !func_value && !ret_pend_reg && rise;
    property p_sls_step;
        idle_press && rise_cmd != RC_NONE && !concept_ls |=>
            tel_valid && tel.kind == TK_STEP && state_reg == ST_THRESH;
    endproperty
    a_sls_step: assert property (p_sls_step) else $error("step missing on press"); // RL6
    property p_ls_move;
        idle_press && rise_cmd != RC_NONE && concept_ls |=>
            tel_valid && tel.kind == TK_MOVE && state_reg == ST_SLAT;
    endproperty
    a_ls_move: assert property (p_ls_move) else $error("move missing on press"); // RL8
    property p_none_silent;
        idle_press && rise_cmd == RC_NONE |=> !tel_valid;
    endproperty
    a_none_silent: assert property (p_none_silent) else $error("disabled input sent"); // RL1
    property p_up_step;
        !func_value && rise_cmd == RC_UP && tel_valid && tel.kind == TK_STEP |-> !tel.dir;
    endproperty
    a_up_step: assert property (p_up_step) else $error("up step went down"); // RL2
    property p_down_step;
        !func_value && rise_cmd == RC_DOWN && tel_valid && tel.kind == TK_STEP |-> tel.dir;
    endproperty
    a_down_step: assert property (p_down_step) else $error("down step went up"); // RL3
    property p_toggle_step;
        idle_press && rise_cmd == RC_TOGGLE && !concept_ls |=> tel.dir == !$past(move_dir_reg);
    endproperty
    a_toggle_step: assert property (p_toggle_step) else $error("step not opposite"); // RL5
    property p_thresh_quiet;
        state_reg == ST_THRESH && fall |=> !tel_valid && state_reg == ST_IDLE;
    endproperty
    a_thresh_quiet: assert property (p_thresh_quiet) else $error("release sent"); // RL6
    property p_thresh_move;
        state_reg == ST_THRESH && !fall && t_done |=>
            tel_valid && tel.kind == TK_MOVE && state_reg == ST_SLAT && tcnt_reg == 19'h00000;
    endproperty
    a_thresh_move: assert property (p_thresh_move) else $error("no move at threshold"); // RL7
    property p_slat_step;
        state_reg == ST_SLAT && fall |=> tel_valid && tel.kind == TK_STEP;
    endproperty
    a_slat_step: assert property (p_slat_step) else $error("no step in window"); // RL7
    property p_sat_top;
        state_reg == ST_HOLD && !release_hold && t_done && adj_up_reg &&
            cur_val_reg == 8'hff |=> cur_val_reg == 8'hff && tel.data == 8'hff;
    endproperty
    a_sat_top: assert property (p_sat_top) else $error("value wrapped"); // RL23

    c_sls_full: cover property (state_reg == ST_SLAT && fall ##1 tel_valid);
    c_hold_adj: cover property (state_reg == ST_HOLD && t_done ##1 tel_valid);
    c_ret_blind: cover property (state_reg == ST_IDLE && ret_pend_reg && !func_value);
endmodule
`default_nettype wire

// file: verification/bvic_contact.sv
// Contact model: a push-button that closes for a set number of cycles.
// Assumes the bench clock; the level changes just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module bvic_contact (
    input wire logic pclk,
    output logic contact_in
);
    initial contact_in = 1'b0;
    task automatic press(input int hold);
        @(posedge pclk);
        contact_in <= 1'b1;
        repeat (hold) @(posedge pclk);
        contact_in <= 1'b0;
    endtask
endmodule
`default_nettype wire

// file: verification/bvic_channel_bench.sv
// Bench for the blind/value channel: a table of press cases, then hand tests.
// Assumes the package and the contact model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module bvic_channel_bench;
    import bvic_pkg::*;
    typedef struct {logic [31:0] blind, valcfg, ctrl; int hold, n; logic [10:0] mask;
        logic [10:0] e [3];} bvic_row_t;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, contact_in, tel_valid, er, s;
    bvic_tel_t tel;
    logic [10:0] q [$];
    bvic_row_t rows [13];
    int fail_count = 0, tests_run = 0;
    initial forever #50 pclk = ~pclk;
    bvic_channel #(.TICK_CYC(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .contact_in(contact_in), .tel(tel),
        .tel_valid(tel_valid));
    bvic_contact contact_u (.pclk(pclk), .contact_in(contact_in));
    always @(posedge pclk) if (tel_valid === 1'b1) q.push_back(tel);
    task automatic chk_word(input string what, input logic [31:0] exp, got);
        tests_run++;
        if (exp !== got) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_tel(input logic [10:0] exp, mask);
        logic [10:0] got;
        got = (q.size() > 0) ? q.pop_front() : 11'hxxx;
        tests_run++;
        if ((got & mask) !== (exp & mask)) begin
            fail_count++;
            $display("BAD tel expected %h seen %h", exp & mask, got & mask);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic print_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #(20000 * 100);
        fail_count++;
        print_verdict;
    end
    initial begin
        rows[0] = '{32'h00500201, RST_VALCFG, 0, 50, 1, 11'h700, '{0, 0, 0}};
        rows[1] = '{32'h00500201, RST_VALCFG, 0, 600, 3, 11'h700, '{0, 11'h200, 0}};
        rows[2] = '{32'h00500202, RST_VALCFG, 0, 50, 1, 11'h700, '{11'h100, 0, 0}};
        rows[3] = '{32'h00500206, RST_VALCFG, 0, 50, 2, 11'h700, '{11'h300, 11'h100, 0}};
        rows[4] = '{32'h00500200, RST_VALCFG, 0, 50, 0, 11'h700, '{0, 0, 0}};
        rows[5] = '{RST_BLIND, 32'h8380, 1, 50, 1, 11'h6ff, '{11'h464, 0, 0}};
        rows[6] = '{RST_BLIND, 32'h8388, 1, 50, 1, 11'h6ff, '{11'h407, 0, 0}};
        rows[7] = '{RST_BLIND, 32'h8390, 1, 50, 2, 11'h6ff, '{11'h464, 11'h407, 0}};
        rows[8] = '{RST_BLIND, 32'h8391, 1, 50, 2, 11'h6ff, '{11'h602, 11'h640, 0}};
        rows[9] = '{RST_BLIND, 32'h8383, 1, 50, 0, 11'h6ff, '{0, 0, 0}};
        rows[10] = '{RST_BLIND, 32'h198390, 3, 0, 1, 11'h6ff, '{11'h407, 0, 0}};
        rows[11] = '{RST_BLIND, 32'h50320, 1, 400, 3, 11'h6ff, '{11'h464, 11'h46e, 11'h478}};
        rows[12] = '{32'h02500201, RST_VALCFG, 2, 0, 1, 11'h700, '{11'h200, 0, 0}};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, OFF_BLIND, 0);
        chk_word("blind", RST_BLIND, rd);
        apb(1'b0, OFF_VALCFG, 0);
        chk_word("valcfg", RST_VALCFG, rd);
        apb(1'b0, 8'h20, 0);
        chk_word("unmapped", 32'h1, {31'h0, er});
        apb(1'b1, OFF_VALUES, 32'h40020764);
        // Row 11 covers stepped adjustment with step width ten.
        foreach (rows[i]) begin
            apb(1'b1, OFF_BLIND, rows[i].blind);
            apb(1'b1, OFF_VALCFG, rows[i].valcfg);
            q.delete();
            apb(1'b1, OFF_CTRL, rows[i].ctrl);
            if (rows[i].hold > 0) contact_u.press(rows[i].hold);
            repeat (30) @(posedge pclk);
            chk_word("count", rows[i].n, q.size());
            for (int k = 0; k < rows[i].n; k++) chk_tel(rows[i].e[k], rows[i].mask);
        end
        apb(1'b1, OFF_BLIND, 32'h00500203);
        apb(1'b1, OFF_CTRL, 0);
        contact_u.press(50);
        repeat (30) @(posedge pclk);
        // The return move above left the held direction up, so this step goes down.
        s = q[0][8];
        chk_word("first step dir", 32'h1, {31'h0, s});
        q.delete();
        contact_u.press(600);
        repeat (30) @(posedge pclk);
        contact_u.press(50);
        repeat (5) @(posedge pclk);
        contact_u.press(50);
        repeat (30) @(posedge pclk);
        chk_tel({2'b00, s, 8'h00}, 11'h700);
        chk_tel({2'b01, s, 8'h00}, 11'h700);
        chk_tel({2'b00, ~s, 8'h00}, 11'h700);
        chk_tel({2'b00, ~s, 8'h00}, 11'h700);
        chk_tel({2'b00, ~s, 8'h00}, 11'h700);
        // Adjustment saturates at both ends; the earlier adjusting hold left it going down.
        apb(1'b1, OFF_VALUES, 32'h40020705);
        apb(1'b1, OFF_VALCFG, 32'h50320);
        apb(1'b1, OFF_CTRL, 32'h1);
        q.delete();
        contact_u.press(200);
        repeat (30) @(posedge pclk);
        apb(1'b1, OFF_VALUES, 32'h400207fa);
        contact_u.press(350);
        repeat (30) @(posedge pclk);
        chk_tel(11'h405, 11'h7ff);
        chk_tel(11'h500, 11'h7ff);
        chk_tel(11'h4fa, 11'h7ff);
        chk_tel(11'h4ff, 11'h7ff);
        chk_tel(11'h4ff, 11'h7ff);
        // A reset in mid-run clears the outputs at once and restores the defaults.
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk_word("outputs in reset", 32'h0, {20'h0, pready, tel});
        presetn <= 1'b1;
        apb(1'b0, OFF_VALUES, 0);
        chk_word("values after reset", RST_VALUES, rd);
        apb(1'b0, OFF_CTRL, 0);
        chk_word("ctrl after reset", RST_CTRL, rd);
        print_verdict;
    end
endmodule
`default_nettype wire
